// >>> logic/vib_pkg.sv
// constants, types and register map of the vibration supervision block
//
// How it works
// [R01] mode zero: no warning, no alarm
// [R02] mode one: excess vibration raises warning only
// [R03] mode two: excess vibration raises the alarm
// [R04] threshold is level over 100 times percent
// [R05] vibration taken from the motor speed signal
// [R06] learning refused unless writes are permitted
// [R07] learning refused unless motorless test is off
// [R08] learning derives a new level from vibration
// [R09] first data key: flash and keep measuring
// [R10] second key: done for one second, commit
// [R11] level writes rejected while learning; sensitivity allowed
// [R12] operator runs learning under real motion
// [R13] mode-set key returns to the main menu; the code ignores it in ST_DONE, which goes on to commit and ST_READY
package vib_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] MODE_OFFSET = 8'h00;
   localparam logic [7:0] SENS_OFFSET = 8'h04;
   localparam logic [7:0] LEVEL_OFFSET = 8'h08;
   localparam logic [7:0] KEYS_OFFSET = 8'h0c;
   localparam logic [7:0] CFG_OFFSET = 8'h10;
   localparam logic [7:0] STATUS_OFFSET = 8'h14;
   localparam logic [7:0] IRQ_STAT_OFFSET = 8'h18;
   localparam logic [7:0] IRQ_MASK_OFFSET = 8'h1c;

   // ==========================================================
   // field positions
   localparam int KEY_DATA_BIT = 0;
   localparam int KEY_SET_BIT = 1;
   localparam int CFG_PERMIT_BIT = 0;
   localparam int CFG_MOTORLESS_LSB = 4;
   localparam int IRQ_WARN_BIT = 0;
   localparam int IRQ_ALARM_BIT = 1;
   localparam int IRQ_DONE_BIT = 2;
   localparam int IRQ_REFUSE_BIT = 3;
   localparam int IRQ_WIDTH = 4;

   // ==========================================================
   // values after reset and limits
   localparam logic [3:0] MODE_RESET = 4'h0;
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_WARN = 4'h1;
   localparam logic [3:0] MODE_ALARM = 4'h2;
   localparam logic [15:0] SENS_RESET = 16'h0064;
   localparam logic [15:0] SENS_MIN = 16'h0032;
   localparam logic [15:0] SENS_MAX = 16'h01f4;
   localparam logic [15:0] LEVEL_RESET = 16'h0100;
   localparam logic [31:0] LEVEL_DIVISOR = 32'h0000_0064;
   localparam logic CFG_PERMIT_RESET = 1'b1;
   localparam logic [3:0] MOTORLESS_RESET = 4'h0;
   localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 4'h0;
   localparam int AVG_SHIFT = 3;

   // ==========================================================
   // timing
   localparam int CLK_MHZ = 100;
   localparam int DONE_TIME_MS = 1000;
   localparam int FLASH_HALF_MS = 250;
   localparam int DONE_CYCLES = DONE_TIME_MS * 1000 * CLK_MHZ;
   localparam int FLASH_CYCLES = FLASH_HALF_MS * 1000 * CLK_MHZ;

   // ==========================================================
   // types
   typedef enum logic [3:0] {
      ST_MENU = 4'b0001,
      ST_READY = 4'b0010,
      ST_LEARN = 4'b0100,
      ST_DONE = 4'b1000
   } learn_state_type;

endpackage

// >>> logic/vib_link_if.sv
// carrier between the speed extractor, the judge and the top
`timescale 1ns/1ps
`default_nettype none
interface vib_link_if;
   logic [15:0] amp;
   logic amp_valid;
   logic exceed;
   modport extract (output amp, output amp_valid);
   modport judge (input amp, input amp_valid, output exceed);
   modport top (input amp, input amp_valid, input exceed);
endinterface
`default_nettype wire

// >>> logic/vib_extract.sv
// vibration amplitude taken from the motor speed samples
`timescale 1ns/1ps
`default_nettype none
module vib_extract
   import vib_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // speed samples
   input wire logic signed [15:0] speed,
   input wire logic speed_valid,
   // amplitude out
   vib_link_if.extract link
);
   logic signed [15:0] avg_q;
   logic signed [16:0] diff;
   logic [16:0] mag;
   logic [15:0] amp_q;
   logic valid_q;

   // ==========================================================
   // slow average; deviation from it is the vibration
   assign diff = 17'(speed) - 17'(avg_q);
   assign mag = diff[16] ? 17'(-diff) : diff;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         avg_q <= 16'sh0000;
      end else if (speed_valid) begin
         avg_q <= 16'(avg_q + 16'(diff >>> AVG_SHIFT)); // [R05]
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         amp_q <= 16'h0000;
         valid_q <= 1'b0;
      end else begin
         valid_q <= speed_valid;
         if (speed_valid) begin
            amp_q <= mag[16] ? 16'hffff : mag[15:0]; // [R05]
         end
      end
   end

   assign link.amp = amp_q;
   assign link.amp_valid = valid_q;

   a_amp_follows: assert property (@(posedge clk) disable iff (!resetn)
      speed_valid && speed == avg_q |=> amp_q == 16'h0000) // [R05]
      else $error("amplitude not zero for steady speed");
endmodule // vib_extract
`default_nettype wire

// >>> logic/vib_judge.sv
// threshold from level and sensitivity, compared with amplitude
`timescale 1ns/1ps
`default_nettype none
module vib_judge
   import vib_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // settings
   input wire logic [15:0] level,
   input wire logic [15:0] sens_pct,
   // amplitude in, verdict out
   vib_link_if.judge link
);
   logic [31:0] product;
   logic [31:0] thresh;
   logic exceed_q;

   // ==========================================================
   // threshold = level * percent / 100
   assign product = 32'(level) * 32'(sens_pct);
   assign thresh = product / LEVEL_DIVISOR; // [R04]

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         exceed_q <= 1'b0;
      end else if (link.amp_valid) begin
         exceed_q <= 32'(link.amp) > thresh; // [R04]
      end
   end

   assign link.exceed = exceed_q;

   a_thresh_calc: assert property (@(posedge clk) disable iff (!resetn)
      link.amp_valid |=> exceed_q ==
         (32'($past(link.amp)) * 32'd100 >
          32'($past(level)) * 32'($past(sens_pct))
          - (32'($past(level)) * 32'($past(sens_pct))) % 32'd100
          + 32'd99)) // [R04]
      else $error("verdict does not match threshold");
endmodule // vib_judge
`default_nettype wire

// >>> logic/vib_supervisor.sv
// vibration supervision top: axi4-lite registers, learning sequence
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module vib_supervisor
   import vib_pkg::*;
#(
   parameter int DONE_COUNT = DONE_CYCLES,
   parameter int FLASH_COUNT = FLASH_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // motor speed feedback
   input wire logic [15:0] speed,
   input wire logic speed_valid,
   // supervision and display outputs
   output logic vib_warning,
   output logic vib_alarm,
   output logic init_flash,
   output logic done_show,
   output logic irq
);
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   vib_link_if link ();

   logic [7:0] awaddr_q;
   logic aw_held_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_held_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic wr_fire;
   logic [31:0] wr_val;
   logic wr_mapped;
   logic [3:0] mode_q;
   logic [15:0] sens_q;
   logic [15:0] level_q;
   logic permit_q;
   logic [3:0] motorless_q;
   logic [IRQ_WIDTH-1:0] irq_stat_q;
   logic [IRQ_WIDTH-1:0] irq_mask_q;
   logic [IRQ_WIDTH-1:0] irq_event;
   learn_state_type state_q;
   learn_state_type state_d;
   logic [15:0] peak_q;
   logic [31:0] done_cnt_q;
   logic [31:0] flash_cnt_q;
   logic flash_q;
   logic warn_q;
   logic alarm_q;
   logic key_data;
   logic key_set;
   logic learn_ok;
   logic refused;
   logic commit;
   logic level_wr;

   // ==========================================================
   // detection path
   vib_extract u_extract (
      .clk(clk),
      .resetn(resetn),
      .speed(speed),
      .speed_valid(speed_valid),
      .link(link.extract)
   );

   vib_judge u_judge (
      .clk(clk),
      .resetn(resetn),
      .level(level_q),
      .sens_pct(sens_q),
      .link(link.judge)
   );

   // ==========================================================
   // axi4-lite write channels, taken in either order
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_val = wdata_q;
      for (int b = 0; b < 4; b++) begin
         if (!wstrb_q[b]) begin
            wr_val[b*8 +: 8] = 8'h00;
         end
      end
      case ({awaddr_q[7:2], 2'b00})
         MODE_OFFSET, SENS_OFFSET, LEVEL_OFFSET, KEYS_OFFSET,
         CFG_OFFSET, IRQ_STAT_OFFSET, IRQ_MASK_OFFSET,
         STATUS_OFFSET: wr_mapped = 1'b1;
         default: wr_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ==========================================================
   // settings written by software
   assign key_data = wr_fire && awaddr_q == KEYS_OFFSET
                     && wr_val[KEY_DATA_BIT];
   assign key_set = wr_fire && awaddr_q == KEYS_OFFSET
                    && wr_val[KEY_SET_BIT];
   assign level_wr = wr_fire && awaddr_q == LEVEL_OFFSET;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= MODE_RESET;
         sens_q <= SENS_RESET;
         permit_q <= CFG_PERMIT_RESET;
         motorless_q <= MOTORLESS_RESET;
         irq_mask_q <= IRQ_MASK_RESET;
      end else if (wr_fire) begin
         case (awaddr_q)
            MODE_OFFSET: mode_q <= wr_val[3:0];
            SENS_OFFSET: begin
               if (wr_val[15:0] >= SENS_MIN && wr_val[15:0] <= SENS_MAX) begin
                  sens_q <= wr_val[15:0]; // [R04] [R11]
               end
            end
            CFG_OFFSET: begin
               permit_q <= wr_val[CFG_PERMIT_BIT];
               motorless_q <= wr_val[CFG_MOTORLESS_LSB +: 4];
            end
            IRQ_MASK_OFFSET: irq_mask_q <= wr_val[IRQ_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // detection level: software or learned value
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         level_q <= LEVEL_RESET;
      end else if (commit) begin
         level_q <= peak_q; // [R10]
      end else if (level_wr && state_q != ST_LEARN
                   && state_q != ST_DONE) begin
         level_q <= wr_val[15:0]; // [R11]
      end
   end

   // ==========================================================
   // learning sequence
   assign learn_ok = permit_q && motorless_q == 4'h0; // [R06] [R07]
   assign refused = state_q == ST_READY && key_data && !learn_ok;
   assign commit = state_q == ST_DONE && done_cnt_q == 32'(DONE_COUNT - 1);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_MENU: if (key_data) state_d = ST_READY;
         ST_READY: begin
            if (key_set) begin
               state_d = ST_MENU; // [R13]
            end else if (key_data && learn_ok) begin
               state_d = ST_LEARN; // [R06] [R07] [R09]
            end
         end
         ST_LEARN: begin
            if (key_set) begin
               state_d = ST_MENU; // [R13]
            end else if (key_data) begin
               state_d = ST_DONE; // [R09] [R10]
            end
         end
         ST_DONE: if (commit) state_d = ST_READY; // [R10]
         default: state_d = ST_MENU;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_MENU;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         peak_q <= 16'h0000;
      end else if (state_q == ST_READY && state_d == ST_LEARN) begin
         peak_q <= 16'h0000;
      end else if (state_q == ST_LEARN && link.amp_valid
                   && link.amp > peak_q) begin
         peak_q <= link.amp; // [R08]
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         done_cnt_q <= 32'h0000_0000;
      end else if (state_q == ST_DONE) begin
         done_cnt_q <= done_cnt_q + 32'h0000_0001; // [R10]
      end else begin
         done_cnt_q <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flash_cnt_q <= 32'h0000_0000;
         flash_q <= 1'b0;
      end else if (state_q != ST_LEARN) begin
         flash_cnt_q <= 32'h0000_0000;
         flash_q <= 1'b0;
      end else if (flash_cnt_q == 32'(FLASH_COUNT - 1)) begin
         flash_cnt_q <= 32'h0000_0000;
         flash_q <= !flash_q; // [R09]
      end else begin
         flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
      end
   end

   // ==========================================================
   // warning and alarm outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         warn_q <= 1'b0;
         alarm_q <= 1'b0;
      end else begin
         warn_q <= link.exceed && mode_q == MODE_WARN; // [R01] [R02]
         alarm_q <= link.exceed && mode_q == MODE_ALARM; // [R01] [R03]
      end
   end

   assign vib_warning = warn_q;
   assign vib_alarm = alarm_q;
   assign init_flash = flash_q;
   assign done_show = state_q == ST_DONE;

   // ==========================================================
   // interrupts: sticky, set wins over write-one-to-clear
   assign irq_event = {refused, commit, alarm_q, warn_q};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_stat_q <= '0;
      end else if (wr_fire && awaddr_q == IRQ_STAT_OFFSET) begin
         irq_stat_q <= (irq_stat_q & ~wr_val[IRQ_WIDTH-1:0]) | irq_event;
      end else begin
         irq_stat_q <= irq_stat_q | irq_event;
      end
   end

   assign irq = |(irq_stat_q & irq_mask_q);

   // ==========================================================
   // axi4-lite read channel
   assign s_axi_arready = !rvalid_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'b00})
            MODE_OFFSET: rdata_q <= {28'h0, mode_q};
            SENS_OFFSET: rdata_q <= {16'h0, sens_q};
            LEVEL_OFFSET: rdata_q <= {16'h0, level_q};
            KEYS_OFFSET: rdata_q <= 32'h0000_0000;
            CFG_OFFSET: rdata_q <= {24'h0, motorless_q, 3'h0, permit_q};
            STATUS_OFFSET: rdata_q <= {peak_q, 8'h0, done_show, flash_q,
                                       alarm_q, warn_q, state_q};
            IRQ_STAT_OFFSET: rdata_q <= {28'h0, irq_stat_q};
            IRQ_MASK_OFFSET: rdata_q <= {28'h0, irq_mask_q};
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_learning_key;
      state_q == ST_LEARN && key_data && !key_set;
   endsequence

   sequence s_done_hold;
      state_q == ST_DONE ##1 state_q == ST_DONE;
   endsequence

   a_mode_off_quiet: assert property ( // [R01]
      mode_q == MODE_OFF ##1 mode_q == MODE_OFF |-> !warn_q && !alarm_q)
      else $error("output raised with supervision off");
   a_warn_only: assert property ( // [R02]
      link.exceed && mode_q == MODE_WARN |=> warn_q && !alarm_q)
      else $error("mode one did not give warning only");
   a_alarm_raise: assert property ( // [R03]
      link.exceed && mode_q == MODE_ALARM |=> alarm_q && !warn_q)
      else $error("mode two did not give alarm");
   a_refuse_protect: assert property ( // [R06]
      state_q == ST_READY && key_data && !key_set && !permit_q
      |=> state_q == ST_READY && irq_stat_q[IRQ_REFUSE_BIT])
      else $error("learning started while protected");
   a_refuse_motorless: assert property ( // [R07]
      state_q == ST_READY && key_data && motorless_q != 4'h0
      |=> state_q != ST_LEARN)
      else $error("learning started in motorless test");
   a_peak_track: assert property ( // [R08]
      state_q == ST_LEARN && link.amp_valid && !key_data && !key_set
      |=> peak_q >= $past(link.amp))
      else $error("learned level below seen vibration");
   a_learn_start: assert property ( // [R09]
      state_q == ST_READY && key_data && !key_set && learn_ok
      |=> state_q == ST_LEARN ##[1:2] state_q == ST_LEARN)
      else $error("learning not entered on data key");
   a_done_enter: assert property ( // [R10]
      s_learning_key |=> s_done_hold ##0 done_show)
      else $error("done indication not shown");
   a_commit_level: assert property ( // [R10]
      commit |=> level_q == $past(peak_q) && state_q == ST_READY)
      else $error("learned level not committed");
   a_level_locked: assert property ( // [R11]
      level_wr && state_q == ST_LEARN |=> level_q == $past(level_q))
      else $error("level written during learning");
   a_menu_return: assert property ( // [R13]
      key_set && (state_q == ST_READY || state_q == ST_LEARN)
      |=> state_q == ST_MENU)
      else $error("mode-set key did not return to menu");
endmodule // vib_supervisor
`default_nettype wire

// >>> test/speed_source.sv
// motor speed feedback model: alternating swing about standstill
`timescale 1ns/1ps
`default_nettype none
module speed_source (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // swing amplitude
   input wire logic [15:0] amp,
   // speed samples
   output logic [15:0] speed,
   output logic speed_valid
);
   // ==========================================================
   // one sample every four cycles, sign flips each sample
   logic [1:0] tick_q;
   logic sign_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tick_q <= 2'd0;
         sign_q <= 1'b0;
         speed <= 16'h0000;
         speed_valid <= 1'b0;
      end else begin
         tick_q <= tick_q + 2'd1;
         speed_valid <= (tick_q == 2'd3);
         if (tick_q == 2'd3) begin
            sign_q <= !sign_q;
            speed <= sign_q ? amp : 16'(-amp);
         end
      end
   end
endmodule // speed_source
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the vibration supervisor
`timescale 1ns/1ps
`default_nettype none
module tb import vib_pkg::*;
;
   // ==========================================================
   // signals
   localparam int DONE_N = 20;
   logic clk, resetn;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rsp;
   logic [15:0] speed, amp;
   logic speed_valid, vib_warning, vib_alarm, init_flash, done_show, irq;
   logic f0, f1;
   int miscompares, compares, cnt;
   logic [15:0] sens_try [4] = '{SENS_MIN - 16'h1, SENS_MIN,
                                 SENS_MAX + 16'h1, SENS_MAX};
   logic [15:0] sens_want [4] = '{SENS_RESET, SENS_MIN, SENS_MIN, SENS_MAX};
   // ==========================================================
   // instances
   speed_source u_src (.clk(clk), .resetn(resetn), .amp(amp),
      .speed(speed), .speed_valid(speed_valid));
   vib_supervisor #(.DONE_COUNT(DONE_N), .FLASH_COUNT(4)) u_dut (
      .clk(clk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .speed(speed), .speed_valid(speed_valid),
      .vib_warning(vib_warning), .vib_alarm(vib_alarm),
      .init_flash(init_flash), .done_show(done_show), .irq(irq));
   always #5 clk = ~clk;
   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      logic aw_h, w_h, b_h;
      int n;
      aw_h = 1'b0;
      w_h = 1'b0;
      b_h = 1'b0;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_h && n < 100) begin
         @(negedge clk);
         aw_h = aw_h | (awvalid & awready);
         w_h = w_h | (wvalid & wready);
         b_h = bvalid;
         rsp = bresp;
         n++;
         @(posedge clk);
         if (aw_h) awvalid <= 1'b0;
         if (w_h) wvalid <= 1'b0;
         if (b_h) bready <= 1'b0;
      end
      if (!b_h) miscompares++;
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      logic ar_h, got;
      int n;
      ar_h = 1'b0;
      got = 1'b0;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got && n < 100) begin
         @(negedge clk);
         ar_h = ar_h | (arvalid & arready);
         got = rvalid;
         d = rdata;
         r = rresp;
         n++;
         @(posedge clk);
         if (ar_h) arvalid <= 1'b0;
         if (got) rready <= 1'b0;
      end
      if (!got) miscompares++;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      axi_read(a, rd, rsp);
      check(rd, e);
   endtask
   task automatic wrap_up;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ==========================================================
   // watchdog
   initial begin
      #100000;
      miscompares++;
      wrap_up;
   end
   // ==========================================================
   // tests
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      {awaddr, araddr, wdata, wstrb, amp} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      miscompares = 0;
      compares = 0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd_chk(MODE_OFFSET, 32'h0);
      rd_chk(SENS_OFFSET, 32'h64);
      rd_chk(LEVEL_OFFSET, {16'h0, LEVEL_RESET});
      rd_chk(IRQ_MASK_OFFSET, 32'h0);
      axi_read(8'h20, rd, rsp);
      check(32'(rsp), 32'h2);
      check(rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         axi_write(SENS_OFFSET, {16'h0, sens_try[i]});
         rd_chk(SENS_OFFSET, {16'h0, sens_want[i]});
      end
      axi_write(SENS_OFFSET, 32'h64);
      check(32'(rsp), 32'h0);
      axi_write(8'h20, 32'h1);
      check(32'(rsp), 32'h2);
      amp <= 16'd1000;
      repeat (200) @(posedge clk);
      for (int m = 0; m < 4; m++) begin
         axi_write(MODE_OFFSET, 32'(m));
         repeat (10) @(negedge clk);
         check(32'(vib_warning), 32'(m == 1));
         check(32'(vib_alarm), 32'(m == 2));
      end
      rd_chk(IRQ_STAT_OFFSET, 32'h3);
      axi_write(IRQ_STAT_OFFSET, 32'h3);
      rd_chk(IRQ_STAT_OFFSET, 32'h0);
      axi_write(MODE_OFFSET, 32'h1);
      axi_write(SENS_OFFSET, 32'h1f4);
      repeat (10) @(negedge clk);
      check(32'(vib_warning), 32'h0);
      axi_write(SENS_OFFSET, 32'h64);
      repeat (10) @(negedge clk);
      check(32'(vib_warning), 32'h1);
      axi_write(MODE_OFFSET, 32'h0);
      axi_write(IRQ_STAT_OFFSET, 32'hf);
      axi_write(IRQ_MASK_OFFSET, 32'h8);
      axi_write(CFG_OFFSET, 32'h0);
      axi_write(KEYS_OFFSET, 32'h1);
      axi_write(KEYS_OFFSET, 32'h1);
      axi_read(STATUS_OFFSET, rd, rsp);
      check(32'(rd[3:0]), 32'h2);
      check(32'(irq), 32'h1);
      axi_write(IRQ_STAT_OFFSET, 32'h8);
      check(32'(irq), 32'h0);
      axi_write(CFG_OFFSET, 32'h11);
      axi_write(KEYS_OFFSET, 32'h1);
      axi_read(STATUS_OFFSET, rd, rsp);
      check(32'(rd[3:0]), 32'h2);
      check(32'(irq), 32'h1);
      axi_write(IRQ_STAT_OFFSET, 32'h8);
      axi_write(IRQ_MASK_OFFSET, 32'h4);
      axi_write(CFG_OFFSET, 32'h1);
      amp <= 16'd600;
      repeat (200) @(posedge clk);
      check(32'(init_flash), 32'h0);
      axi_write(KEYS_OFFSET, 32'h1);
      axi_read(STATUS_OFFSET, rd, rsp);
      check(32'(rd[3:0]), 32'h4);
      f0 = 1'b0;
      f1 = 1'b0;
      repeat (12) @(negedge clk) begin
         f1 = f1 | (init_flash === 1'b1);
         f0 = f0 | (init_flash === 1'b0);
      end
      check(32'({f1, f0}), 32'h3);
      axi_write(LEVEL_OFFSET, 32'h50);
      rd_chk(LEVEL_OFFSET, {16'h0, LEVEL_RESET});
      axi_write(SENS_OFFSET, 32'hc8);
      rd_chk(SENS_OFFSET, 32'hc8);
      axi_write(KEYS_OFFSET, 32'h1);
      check(32'(done_show), 32'h1);
      cnt = 0;
      while (done_show === 1'b1 && cnt < 100) begin
         @(negedge clk);
         cnt++;
      end
      check(32'(cnt >= DONE_N - 3 && cnt <= DONE_N), 32'h1);
      axi_read(LEVEL_OFFSET, rd, rsp);
      check(32'(rd >= 32'd600 && rd <= 32'd720), 32'h1);
      check(32'(irq), 32'h1);
      axi_write(KEYS_OFFSET, 32'h2);
      axi_read(STATUS_OFFSET, rd, rsp);
      check(32'(rd[3:0]), 32'h1);
      wrap_up;
   end
endmodule // tb
`default_nettype wire
